/* trto_regs.vh */
// Constants for the timer register transfer block: operations, offsets, fields, resets
// What this block does
// - Select-control write copies the accumulator into the timer select register.
// - Control register read puts the chosen one of four registers into accumulator.
// - Control register write loads the chosen one of four from the accumulator.
// - Prescaler read returns upper nibble in second register, lower in accumulator.
// - Prescaler write loads count and reload, upper from second, lower from accumulator.
// - Timer 1 read returns upper nibble in second register, lower in accumulator.
// - Timer 1 write loads counter and reload together from the two CPU registers.
// - Timer 2 read returns upper nibble in second register, lower in accumulator.
// - Timer 2 write loads counter and low reload together from the two registers.
// - High reload write loads only timer 2 high reload; counter stays untouched.
// - Timer 1 reload-only write updates the reload, leaving the running count alone.
// - Reload transfer copies timer 2 low reload into the timer 2 counter.
// - Display timer write loads display counter and its reload from accumulator.
// - Timer 1 flag test, enable 0: flag set clears it and skips; enable 1 no-op.
// - Timer 2 flag test, enable 0: flag set clears it and skips; enable 1 no-op.
// - Timer 3 flag test, enable 0: flag set clears it and skips; enable 1 no-op.
// - Timer 1/2 enables are bits 2/3 of first control; timer 3 bit 0 of second.
`ifndef TRTO_REGS_VH
`define TRTO_REGS_VH

// Operation codes on op_code
`define TRTO_OP_SEL_WR    5'h00
`define TRTO_OP_CTRL1_RD  5'h01
`define TRTO_OP_CTRL1_WR  5'h02
`define TRTO_OP_CTRL2_RD  5'h03
`define TRTO_OP_CTRL2_WR  5'h04
`define TRTO_OP_CTRL3_RD  5'h05
`define TRTO_OP_CTRL3_WR  5'h06
`define TRTO_OP_CTRL4_RD  5'h07
`define TRTO_OP_CTRL4_WR  5'h08
`define TRTO_OP_PRE_RD    5'h09
`define TRTO_OP_PRE_WR    5'h0A
`define TRTO_OP_T1_RD     5'h0B
`define TRTO_OP_T1_WR     5'h0C
`define TRTO_OP_T2_RD     5'h0D
`define TRTO_OP_T2_WR     5'h0E
`define TRTO_OP_T2H_WR    5'h0F
`define TRTO_OP_T1R_WR    5'h10
`define TRTO_OP_T2_XFER   5'h11
`define TRTO_OP_DISP_WR   5'h12
`define TRTO_OP_T1_TEST   5'h13
`define TRTO_OP_T2_TEST   5'h14
`define TRTO_OP_T3_TEST   5'h15

// Register bus offsets
`define TRTO_ADDR_IRQ_FIRST   4'h0
`define TRTO_ADDR_IRQ_SECOND  4'h1
`define TRTO_ADDR_STATUS      4'h2
`define TRTO_ADDR_MASK        4'h3
`define TRTO_ADDR_SELECT      4'h4
`define TRTO_ADDR_CTRL_LO     4'h5
`define TRTO_ADDR_CTRL_HI     4'h6

// Field positions
`define TRTO_BIT_T1_EN    2
`define TRTO_BIT_T2_EN    3
`define TRTO_BIT_T3_EN    0
`define TRTO_BIT_T1_FLAG  0
`define TRTO_BIT_T2_FLAG  1
`define TRTO_BIT_T3_FLAG  2

// Reset values
`define TRTO_RST_NIB   4'h0
`define TRTO_RST_BYTE  8'h00
`define TRTO_RST_FLAGS 3'h0

`endif

/* trto_core.v */
// Timer register transfer logic with flag tests and a small register port
`timescale 1ns/100ps
`include "trto_regs.vh"

module trto_core
(
  input  wire       clock,
  input  wire       reset,
  input  wire       op_valid,
  input  wire [4:0] op_code,
  input  wire [3:0] acc_in,
  input  wire [3:0] breg_in,
  input  wire       prescaler_tick,
  input  wire       timer_one_tick,
  input  wire       timer_two_tick,
  input  wire       display_tick,
  input  wire       timer_one_event,
  input  wire       timer_two_event,
  input  wire       timer_three_event,
  input  wire [3:0] bus_addr,
  input  wire [7:0] bus_wdata,
  input  wire       bus_write,
  input  wire       bus_read,
  output reg  [7:0] bus_rdata,
  output reg  [3:0] acc_out,
  output reg  [3:0] breg_out,
  output reg        acc_load,
  output reg        breg_load,
  output reg        skip_next,
  output reg        irq,
  output reg  [3:0] timer_select_control,
  output reg  [3:0] timer_ctrl_one,
  output reg  [3:0] timer_ctrl_two,
  output reg  [3:0] timer_ctrl_three,
  output reg  [3:0] timer_ctrl_four,
  output reg  [7:0] prescaler_count,
  output reg  [7:0] timer_one_count,
  output reg  [7:0] timer_two_count,
  output reg  [3:0] display_timer
);

  // Internal storage
  reg [7:0] prescaler_reload;
  reg [7:0] timer_one_reload;
  reg [7:0] timer_two_low_reload;
  reg [7:0] timer_two_high_reload;
  reg [3:0] display_timer_reload;
  reg [3:0] irq_ctrl_first;
  reg [3:0] irq_ctrl_second;
  reg [2:0] flags_reg;
  reg [2:0] mask_reg;

  // Decoded operation strobes
  wire go = op_valid;
  wire [7:0] ba_word = {breg_in, acc_in};
  wire t1_en = irq_ctrl_first[`TRTO_BIT_T1_EN];
  wire t2_en = irq_ctrl_first[`TRTO_BIT_T2_EN];
  wire t3_en = irq_ctrl_second[`TRTO_BIT_T3_EN];

  // Enables lined up with the flag bits so the test logic can be generated
  wire [2:0] test_en = {t3_en, t2_en, t1_en};
  wire [2:0] test_hit;
  wire [2:0] flags_next;

  wire       bus_wr_status = bus_write && bus_addr == `TRTO_ADDR_STATUS;
  wire [2:0] events = {timer_three_event, timer_two_event, timer_one_event};
  wire [2:0] w1c = bus_wr_status ? bus_wdata[2:0] : 3'h0;

  // Down-count step shared by the prescaler and timers 1 and 2: reload when the count is spent
  function [7:0] step8;
    input [7:0] cnt;
    input [7:0] rld;
    begin
      step8 = (cnt == 8'h00) ? rld : cnt - 8'h01;
    end
  endfunction

  // Flag test operation code for timer index 0..2
  function [4:0] test_code;
    input integer idx;
    begin
      if (idx == 0)
        test_code = `TRTO_OP_T1_TEST;
      else if (idx == 1)
        test_code = `TRTO_OP_T2_TEST;
      else
        test_code = `TRTO_OP_T3_TEST;
    end
  endfunction

  // Read-back answer to the CPU, one cycle after the operation
  always @(posedge clock)
  begin
    if (reset)
    begin
      acc_out   <= `TRTO_RST_NIB;
      breg_out  <= `TRTO_RST_NIB;
      acc_load  <= 1'b0;
      breg_load <= 1'b0;
      skip_next <= 1'b0;
    end
    else
    begin
      acc_load  <= 1'b0;
      breg_load <= 1'b0;
      skip_next <= |test_hit;
      if (go)
      begin
        case (op_code)
          `TRTO_OP_CTRL1_RD:
          begin
            acc_out  <= timer_ctrl_one;
            acc_load <= 1'b1;
          end
          `TRTO_OP_CTRL2_RD:
          begin
            acc_out  <= timer_ctrl_two;
            acc_load <= 1'b1;
          end
          `TRTO_OP_CTRL3_RD:
          begin
            acc_out  <= timer_ctrl_three;
            acc_load <= 1'b1;
          end
          `TRTO_OP_CTRL4_RD:
          begin
            acc_out  <= timer_ctrl_four;
            acc_load <= 1'b1;
          end
          `TRTO_OP_PRE_RD:
          begin
            breg_out  <= prescaler_count[7:4];
            acc_out   <= prescaler_count[3:0];
            acc_load  <= 1'b1;
            breg_load <= 1'b1;
          end
          `TRTO_OP_T1_RD:
          begin
            breg_out  <= timer_one_count[7:4];
            acc_out   <= timer_one_count[3:0];
            acc_load  <= 1'b1;
            breg_load <= 1'b1;
          end
          `TRTO_OP_T2_RD:
          begin
            breg_out  <= timer_two_count[7:4];
            acc_out   <= timer_two_count[3:0];
            acc_load  <= 1'b1;
            breg_load <= 1'b1;
          end
          default:
          begin
            acc_load <= 1'b0;
          end
        endcase
      end
    end
  end

  // Timer control registers written from the accumulator
  always @(posedge clock)
  begin
    if (reset)
    begin
      timer_select_control <= `TRTO_RST_NIB;
      timer_ctrl_one       <= `TRTO_RST_NIB;
      timer_ctrl_two       <= `TRTO_RST_NIB;
      timer_ctrl_three     <= `TRTO_RST_NIB;
      timer_ctrl_four      <= `TRTO_RST_NIB;
    end
    else if (go)
    begin
      if (op_code == `TRTO_OP_SEL_WR)
        timer_select_control <= acc_in;
      if (op_code == `TRTO_OP_CTRL1_WR)
        timer_ctrl_one <= acc_in;
      if (op_code == `TRTO_OP_CTRL2_WR)
        timer_ctrl_two <= acc_in;
      if (op_code == `TRTO_OP_CTRL3_WR)
        timer_ctrl_three <= acc_in;
      if (op_code == `TRTO_OP_CTRL4_WR)
        timer_ctrl_four <= acc_in;
    end
  end

  // Prescaler; a CPU load beats a count tick in the same cycle.
  // Reads touch none of the counters, so counting runs on undisturbed.
  always @(posedge clock)
  begin
    if (reset)
    begin
      prescaler_count  <= `TRTO_RST_BYTE;
      prescaler_reload <= `TRTO_RST_BYTE;
    end
    else
    begin
      if (go && op_code == `TRTO_OP_PRE_WR)
      begin
        prescaler_count  <= ba_word;
        prescaler_reload <= ba_word;
      end
      else if (prescaler_tick)
        prescaler_count <= step8(prescaler_count, prescaler_reload);
    end
  end

  // Timer 1: full write or reload-only write; a tick still uses the old reload
  always @(posedge clock)
  begin
    if (reset)
    begin
      timer_one_count  <= `TRTO_RST_BYTE;
      timer_one_reload <= `TRTO_RST_BYTE;
    end
    else
    begin
      if (go && op_code == `TRTO_OP_T1_WR)
      begin
        timer_one_count  <= ba_word;
        timer_one_reload <= ba_word;
      end
      else
      begin
        if (go && op_code == `TRTO_OP_T1R_WR)
          timer_one_reload <= ba_word;
        if (timer_one_tick)
          timer_one_count <= step8(timer_one_count, timer_one_reload);
      end
    end
  end

  // Timer 2: counter loads from the CPU or from its low reload
  always @(posedge clock)
  begin
    if (reset)
    begin
      timer_two_count       <= `TRTO_RST_BYTE;
      timer_two_low_reload  <= `TRTO_RST_BYTE;
      timer_two_high_reload <= `TRTO_RST_BYTE;
    end
    else
    begin
      if (go && op_code == `TRTO_OP_T2_WR)
      begin
        timer_two_count      <= ba_word;
        timer_two_low_reload <= ba_word;
      end
      else if (go && op_code == `TRTO_OP_T2_XFER)
        timer_two_count <= timer_two_low_reload;
      else if (timer_two_tick)
        timer_two_count <= step8(timer_two_count, timer_two_low_reload);
      // High reload is only stored; nothing here counts with it yet
      if (go && op_code == `TRTO_OP_T2H_WR)
        timer_two_high_reload <= ba_word;
    end
  end

  // Display timer, loaded from the accumulator only
  always @(posedge clock)
  begin
    if (reset)
    begin
      display_timer        <= `TRTO_RST_NIB;
      display_timer_reload <= `TRTO_RST_NIB;
    end
    else if (go && op_code == `TRTO_OP_DISP_WR)
    begin
      display_timer        <= acc_in;
      display_timer_reload <= acc_in;
    end
    else if (display_tick)
      display_timer <= (display_timer == 4'h0) ? display_timer_reload
                       : display_timer - 4'h1;
  end

  // Request flags: timer events set, skipping tests and bus writes of one clear.
  // Set wins, so an event landing on the clearing cycle is not lost.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_flag
      // A test only takes effect with its enable low and its flag set
      assign test_hit[gi] = go && op_code == test_code(gi) && !test_en[gi]
                            && flags_reg[gi];
      assign flags_next[gi] = (flags_reg[gi] && !test_hit[gi] && !w1c[gi])
                              || events[gi];
    end
  endgenerate

  // One register holds all three flags
  always @(posedge clock)
  begin
    if (reset)
      flags_reg <= `TRTO_RST_FLAGS;
    else
      flags_reg <= flags_next;
  end

  // Software registers: enables, mask and interrupt output
  always @(posedge clock)
  begin
    if (reset)
    begin
      irq_ctrl_first  <= `TRTO_RST_NIB;
      irq_ctrl_second <= `TRTO_RST_NIB;
      mask_reg        <= `TRTO_RST_FLAGS;
      irq             <= 1'b0;
    end
    else
    begin
      if (bus_write && bus_addr == `TRTO_ADDR_IRQ_FIRST)
        irq_ctrl_first <= bus_wdata[3:0];
      else if (bus_write && bus_addr == `TRTO_ADDR_IRQ_SECOND)
        irq_ctrl_second <= bus_wdata[3:0];
      else if (bus_write && bus_addr == `TRTO_ADDR_MASK)
        mask_reg <= bus_wdata[2:0];
      // Registered, so it trails the flag by one cycle
      irq <= |(flags_reg & mask_reg);
    end
  end

  // Read data, valid only the cycle after the read strobe
  always @(posedge clock)
  begin
    if (reset)
      bus_rdata <= `TRTO_RST_BYTE;
    else if (!bus_read)
      bus_rdata <= `TRTO_RST_BYTE;
    else if (bus_addr == `TRTO_ADDR_IRQ_FIRST)
      bus_rdata <= {4'h0, irq_ctrl_first};
    else if (bus_addr == `TRTO_ADDR_IRQ_SECOND)
      bus_rdata <= {4'h0, irq_ctrl_second};
    else if (bus_addr == `TRTO_ADDR_STATUS)
      bus_rdata <= {5'h00, flags_reg};
    else if (bus_addr == `TRTO_ADDR_MASK)
      bus_rdata <= {5'h00, mask_reg};
    else if (bus_addr == `TRTO_ADDR_SELECT)
      bus_rdata <= {4'h0, timer_select_control};
    else if (bus_addr == `TRTO_ADDR_CTRL_LO)
      bus_rdata <= {timer_ctrl_two, timer_ctrl_one};
    else if (bus_addr == `TRTO_ADDR_CTRL_HI)
      bus_rdata <= {timer_ctrl_four, timer_ctrl_three};
    else
      bus_rdata <= `TRTO_RST_BYTE;  // Unmapped reads as zero
  end

endmodule // trto_core

/* trto_cpu_model.sv */
// Behavioural model of the CPU instruction executor driving the transfer port
`timescale 1ns/100ps

module trto_cpu_model
(
  input  wire logic       clock,
  input  wire logic [3:0] acc_out,
  input  wire logic [3:0] breg_out,
  input  wire logic       skip_next,
  output logic            op_valid,
  output logic [4:0]      op_code,
  output logic [3:0]      acc_in,
  output logic [3:0]      breg_in
);
  // Idle: no instruction, operand lines hold a neutral value
  initial
  begin
    op_valid = 1'b0;
    op_code  = 5'h1F;
    acc_in   = 4'h0;
    breg_in  = 4'h0;
  end

  // One instruction; operands inverted afterwards so stale values never pass for fresh ones
  task automatic run(input logic [4:0] c, input logic [7:0] ba, output logic [7:0] r,
                     output logic s);
    @(posedge clock);
    op_valid <= 1'b1;
    op_code  <= c;
    breg_in  <= ba[7:4]; // Upper nibble travels in B
    acc_in   <= ba[3:0];
    @(posedge clock);
    op_valid <= 1'b0;
    breg_in  <= ~ba[7:4];
    acc_in   <= ~ba[3:0];
    @(negedge clock);
    r = {breg_out, acc_out};
    s = skip_next;
  endtask
endmodule // trto_cpu_model

/* trto_core_chk.sv */
// Port-level assertions for the timer register transfer core
`timescale 1ns/100ps
`include "trto_regs.vh"

module trto_core_chk
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       op_valid,
  input wire logic [4:0] op_code,
  input wire logic [3:0] acc_in,
  input wire logic [3:0] breg_in,
  input wire logic       timer_two_tick,
  input wire logic [3:0] acc_out,
  input wire logic [3:0] breg_out,
  input wire logic       acc_load,
  input wire logic       breg_load,
  input wire logic       skip_next,
  input wire logic [3:0] timer_select_control,
  input wire logic [3:0] timer_ctrl_one,
  input wire logic [7:0] prescaler_count,
  input wire logic [7:0] timer_one_count,
  input wire logic [7:0] timer_two_count,
  input wire logic [3:0] display_timer
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // An instruction of the given code taken at this edge
  sequence s_op(logic [4:0] c);
    op_valid && op_code == c;
  endsequence

  // The B:A pair presented with the instruction
  sequence s_pair_loaded(logic [7:0] v);
    v == {$past(breg_in), $past(acc_in)};
  endsequence

  AST_SEL_WR: assert property (s_op(`TRTO_OP_SEL_WR) |=>
    timer_select_control == $past(acc_in)) else $error("select write lost");
  AST_CTRL_RD: assert property (s_op(`TRTO_OP_CTRL1_RD) |=>
    acc_load && acc_out == $past(timer_ctrl_one)) else $error("control read wrong");
  AST_CTRL_WR: assert property (s_op(`TRTO_OP_CTRL1_WR) |=>
    timer_ctrl_one == $past(acc_in)) else $error("control write lost");
  AST_PRE_WR: assert property (s_op(`TRTO_OP_PRE_WR) |=>
    s_pair_loaded(prescaler_count)) else $error("prescaler write wrong");
  AST_T1_RD: assert property (s_op(`TRTO_OP_T1_RD) |=>
    acc_load && breg_load && {breg_out, acc_out} == $past(timer_one_count))
    else $error("timer one read wrong");
  AST_T1_WR: assert property (s_op(`TRTO_OP_T1_WR) |=>
    s_pair_loaded(timer_one_count)) else $error("timer one write wrong");
  AST_T2_WR: assert property (s_op(`TRTO_OP_T2_WR) |=>
    s_pair_loaded(timer_two_count)) else $error("timer two write wrong");
  AST_T2H_KEEP: assert property (s_op(`TRTO_OP_T2H_WR) && !timer_two_tick |=>
    $stable(timer_two_count)) else $error("high reload touched counter");
  AST_DISP_WR: assert property (s_op(`TRTO_OP_DISP_WR) |=>
    display_timer == $past(acc_in)) else $error("display write lost");
  AST_SKIP_CAUSE: assert property (skip_next |-> $past(op_valid) &&
    $past(op_code) >= `TRTO_OP_T1_TEST && $past(op_code) <= `TRTO_OP_T3_TEST)
    else $error("skip without flag test");
endmodule // trto_core_chk

bind trto_core trto_core_chk u_chk
(
  .clock, .reset, .op_valid, .op_code, .acc_in, .breg_in, .timer_two_tick, .acc_out,
  .breg_out, .acc_load, .breg_load, .skip_next, .timer_select_control, .timer_ctrl_one,
  .prescaler_count, .timer_one_count, .timer_two_count, .display_timer
);

/* test_timer_register_transfer_ops.sv */
// Self-checking testbench for the timer register transfer core
`timescale 1ns/100ps
`include "trto_regs.vh"

module test_timer_register_transfer_ops;
  logic       clock, reset, op_valid, timer_two_tick, bus_write, bus_read, skip_next, irq;
  logic       timer_one_event, timer_two_event, timer_three_event, acc_load, breg_load;
  logic       timer_one_tick;
  logic [4:0] op_code;
  logic [3:0] acc_in, breg_in, acc_out, breg_out, bus_addr, display_timer;
  logic [3:0] timer_select_control, timer_ctrl_one, timer_ctrl_two, timer_ctrl_three;
  logic [3:0] timer_ctrl_four;
  logic [7:0] bus_wdata, bus_rdata, prescaler_count, timer_one_count, timer_two_count;
  logic [7:0] r;
  logic       s;
  integer     failures = 0;
  integer     n_checks = 0;

  trto_core dut
  (
    .clock, .reset, .op_valid, .op_code, .acc_in, .breg_in, .prescaler_tick(1'b0),
    .timer_one_tick, .timer_two_tick, .display_tick(1'b0), .timer_one_event,
    .timer_two_event, .timer_three_event, .bus_addr, .bus_wdata, .bus_write, .bus_read,
    .bus_rdata, .acc_out, .breg_out, .acc_load, .breg_load, .skip_next, .irq,
    .timer_select_control, .timer_ctrl_one, .timer_ctrl_two, .timer_ctrl_three,
    .timer_ctrl_four, .prescaler_count, .timer_one_count, .timer_two_count, .display_timer
  );

  trto_cpu_model cpu
  (
    .clock, .acc_out, .breg_out, .skip_next, .op_valid, .op_code, .acc_in, .breg_in
  );

  // Free-running 100 ns clock
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task end_sim;
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Register port cycles: one-cycle strobes, read data only in the following cycle
  task bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clock);
    bus_write <= 1'b0;
  endtask

  task bus_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clock);
    bus_read <= 1'b0;
    @(negedge clock);
    chk(bus_rdata, exp);
  endtask

  // Single-cycle pulse on one timer event line
  task evt(input int k);
    @(posedge clock);
    {timer_three_event, timer_two_event, timer_one_event} <= 3'h1 << k;
    @(posedge clock);
    {timer_three_event, timer_two_event, timer_one_event} <= 3'h0;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    failures++;
    end_sim;
  end

  initial
  begin
    {reset, timer_two_tick, bus_write, bus_read, bus_addr, bus_wdata} = {1'b1, 15'h0000};
    {timer_three_event, timer_two_event, timer_one_event} = 3'h0;
    timer_one_tick = 1'b0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk(timer_one_count, 8'h00);
    cpu.run(`TRTO_OP_SEL_WR, 8'h0B, r, s);
    chk(timer_select_control, 4'hB);
    // Four control registers: write, then read back through A
    for (int k = 0; k < 4; k++)
    begin
      cpu.run(`TRTO_OP_CTRL1_WR + 2 * k, 8'h06 + k, r, s);
      cpu.run(`TRTO_OP_CTRL1_RD + 2 * k, 8'hF0, r, s);
      chk(r[3:0], 4'h6 + k);
    end
    chk({timer_ctrl_four, timer_ctrl_three, timer_ctrl_two, timer_ctrl_one}, 16'h9876);
    cpu.run(`TRTO_OP_PRE_WR, 8'hA5, r, s);
    chk(prescaler_count, 8'hA5);
    cpu.run(`TRTO_OP_PRE_RD, 8'h00, r, s);
    chk(r, 8'hA5);
    cpu.run(`TRTO_OP_T1_WR, 8'h3C, r, s);
    cpu.run(`TRTO_OP_T1R_WR, 8'h71, r, s);
    cpu.run(`TRTO_OP_T1_RD, 8'h00, r, s);
    chk(r, 8'h3C);
    // Spent count must pick up the reload written alone
    cpu.run(`TRTO_OP_T1_WR, 8'h00, r, s);
    cpu.run(`TRTO_OP_T1R_WR, 8'h71, r, s);
    chk(timer_one_count, 8'h00);
    @(posedge clock);
    timer_one_tick <= 1'b1;
    @(posedge clock);
    timer_one_tick <= 1'b0;
    @(negedge clock);
    chk(timer_one_count, 8'h71);
    cpu.run(`TRTO_OP_T2_WR, 8'h5E, r, s);
    cpu.run(`TRTO_OP_T2H_WR, 8'h99, r, s);
    chk(timer_two_count, 8'h5E);
    // Three count steps, then the read must not disturb the count
    @(posedge clock);
    timer_two_tick <= 1'b1;
    repeat (3) @(posedge clock);
    timer_two_tick <= 1'b0;
    cpu.run(`TRTO_OP_T2_RD, 8'h00, r, s);
    chk(r, 8'h5B);
    chk(timer_two_count, 8'h5B);
    cpu.run(`TRTO_OP_T2_XFER, 8'h00, r, s);
    chk(timer_two_count, 8'h5E);
    cpu.run(`TRTO_OP_DISP_WR, 8'h0C, r, s);
    chk(display_timer, 4'hC);
    // Flag tests: enabled is a no-op, disabled clears and skips once
    for (int k = 0; k < 3; k++)
    begin
      bus_wr(k == 2, k == 0 ? 8'h04 : k == 1 ? 8'h08 : 8'h01);
      evt(k);
      cpu.run(`TRTO_OP_T1_TEST + k, 8'h00, r, s);
      chk(s, 1'b0);
      bus_rd(4'h2, 8'h01 << k);
      bus_wr(k == 2, 8'h00);
      cpu.run(`TRTO_OP_T1_TEST + k, 8'h00, r, s);
      chk(s, 1'b1);
      bus_rd(4'h2, 8'h00);
      cpu.run(`TRTO_OP_T1_TEST + k, 8'h00, r, s);
      chk(s, 1'b0);
    end
    // Interrupt: masked event stays quiet, unmasked raises, write-one clears
    evt(1);
    repeat (2) @(negedge clock);
    chk(irq, 1'b0);
    bus_wr(4'h3, 8'h07);
    repeat (2) @(negedge clock);
    chk(irq, 1'b1);
    bus_wr(4'h2, 8'h02);
    repeat (2) @(negedge clock);
    chk(irq, 1'b0);
    bus_rd(4'hF, 8'h00);
    end_sim;
  end
endmodule // test_timer_register_transfer_ops
